// ### verilog/bscas_pkg.sv
/*
 * Shared constants, types and helper functions for the beam smoothing
 * and cascade trigger block.
 * Assumes a single 10 MHz clock and byte-wide serial frames delivered
 * by an external character receiver on the same clock.
 */
package bscas_pkg;

   // ------------------------------------------------------------------
   // Time base
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int US_NS = 1000;
   localparam int MS_NS = 1000000;
   localparam int CLKS_PER_US = US_NS / CLK_PERIOD_NS;
   localparam int CLKS_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam int TRIG_PULSE_US = 1;
   localparam int TRIG_CLKS = TRIG_PULSE_US * CLKS_PER_US;
   localparam int MB_GAP_US = 2000;
   localparam int MB_GAP_CLKS = MB_GAP_US * CLKS_PER_US;

   // ------------------------------------------------------------------
   // Serial parameter frames
   // ------------------------------------------------------------------
   localparam logic [7:0] MB_UNIT = 8'h01;
   localparam logic [7:0] MB_FN_WR_MULTI = 8'h10;
   localparam logic [15:0] REG_SMOOTH_CFG = 16'h0047;
   localparam logic [15:0] MB_QTY = 16'h0002;
   localparam logic [7:0] MB_BYTE_CNT = 8'h04;
   localparam logic [3:0] MB_HDR_LEN = 4'h7;
   localparam logic [3:0] MB_REQ_LAST = 4'hc;
   localparam logic [3:0] MB_RSP_HDR = 4'h6;
   localparam logic [3:0] MB_RSP_LAST = 4'h7;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;

   // ------------------------------------------------------------------
   // Smoothing configuration word
   // ------------------------------------------------------------------
   localparam logic [31:0] SMOOTH_CFG_RST = 32'h0000_0101;
   localparam int THR_W = 8;
   localparam int SMOOTH_LSB = 8;
   localparam int INV_LSB = 0;
   localparam int IOL_W = 16;

   // ------------------------------------------------------------------
   // Role and pin codes
   // ------------------------------------------------------------------
   localparam logic ROLE_MASTER = 1'b1;
   localparam logic PIN_DIR_OUT = 1'b0;
   localparam logic PIN_DIR_IN = 1'b1;
   localparam logic PIN_SW_LIGHT = 1'b0;
   localparam logic [3:0] PIN_FN_TRIG_OUT = 4'h3;
   localparam logic [3:0] PIN_FN_TRIG_IN = 4'h1;

   typedef enum logic [1:0] {
      CS_OFF = 2'b00,
      CS_MASTER = 2'b01,
      CS_SLAVE = 2'b11
   } bscas_state_t;

   // Fixed header byte of request and reply by position
   function automatic logic [7:0] mb_hdr_byte(input logic [3:0] idx);
      case (idx)
         4'h0: return MB_UNIT;
         4'h1: return MB_FN_WR_MULTI;
         4'h2: return REG_SMOOTH_CFG[15:8];
         4'h3: return REG_SMOOTH_CFG[7:0];
         4'h4: return MB_QTY[15:8];
         4'h5: return MB_QTY[7:0];
         default: return MB_BYTE_CNT;
      endcase
   endfunction

   // One byte step of the reflected frame check sequence
   function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

endpackage

// ### verilog/bscas_timer.sv
/*
 * Restartable interval timer: counts a number of units of TICK clocks
 * and pulses done_o once at the end.
 * Assumes TICK is at least 2; start_i may arrive while running.
 */
`timescale 1ns/10ps
module bscas_timer #(
   parameter int TICK = 10,
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic start_i,
   input wire logic [W-1:0] units_i,
   output logic done_o
);

   localparam int PW = $clog2(TICK + 1);
   localparam logic [PW-1:0] PRE_ONE = PW'(1);
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK - 1);

   logic [PW-1:0] pre_q;
   logic [W-1:0] units_q;
   logic busy_q;

   // Start cycle counts as the first clock of the first unit
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pre_q <= '0;
         units_q <= '0;
         busy_q <= 1'b0;
         done_o <= 1'b0;
      end else if (start_i) begin
         pre_q <= PRE_ONE;
         units_q <= units_i;
         busy_q <= (units_i != '0);
         done_o <= (units_i == '0);
      end else if (busy_q && pre_q == PRE_LAST) begin
         pre_q <= '0;
         units_q <= units_q - W'(1);
         busy_q <= (units_q != W'(1));
         done_o <= (units_q == W'(1));
      end else begin
         pre_q <= busy_q ? pre_q + PW'(1) : pre_q;
         done_o <= 1'b0;
      end
   end

endmodule

// ### verilog/bscas_smooth.sv
/*
 * Beam evaluation with smoothing and inverted smoothing thresholds.
 * Assumes beam states are already synchronised; a set bit is an
 * interrupted beam. A threshold of 0 or 1 means no filtering.
 */
`timescale 1ns/10ps
module bscas_smooth
   import bscas_pkg::*;
#(
   parameter int NB = 16
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [NB-1:0] beams_i,
   input wire logic [THR_W-1:0] thr_intr_i,
   input wire logic [THR_W-1:0] thr_free_i,
   output logic [NB-1:0] intr_eval_o,
   output logic [NB-1:0] free_eval_o,
   output logic intr_det_o,
   output logic free_det_o
);

   // Number of set bits
   function automatic logic [8:0] popcnt(input logic [NB-1:0] v);
      logic [8:0] c;
      c = '0;
      for (int i = 0; i < NB; i++) begin
         c = c + {8'h00, v[i]};
      end
      return c;
   endfunction

   // Zero acts like one: nothing is filtered
   function automatic logic [8:0] thr_eff(input logic [THR_W-1:0] t);
      return (t == '0) ? 9'h001 : {1'b0, t};
   endfunction

   logic intr_hit;
   logic free_hit;

   // Threshold compare on both beam states
   assign intr_hit = popcnt(beams_i) >= thr_eff(thr_intr_i);
   assign free_hit = popcnt(~beams_i) >= thr_eff(thr_free_i);

   // Registered evaluation result
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         intr_det_o <= 1'b0;
         free_det_o <= 1'b0;
         intr_eval_o <= '0;
         free_eval_o <= '0;
      end else begin
         intr_det_o <= intr_hit;
         free_det_o <= free_hit;
         intr_eval_o <= intr_hit ? beams_i : '0;
         free_eval_o <= free_hit ? ~beams_i : '0;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   smooth_intr_a: assert property (
      intr_det_o |-> $past(popcnt(beams_i)) >= $past(thr_eff(thr_intr_i)))
      else $error("interrupted beams passed below threshold");
   smooth_free_a: assert property (
      (popcnt(~beams_i) < thr_eff(thr_free_i)) |=> (free_eval_o == '0 && !free_det_o))
      else $error("free beams passed below threshold");

endmodule

// ### verilog/bscas_top.sv
/*
 * Beam smoothing and cascade trigger logic of a light-curtain receiver:
 * serial parameter write of the smoothing word with reply, IO-Link
 * style object write, master trigger generation and slave delayed scan.
 * Assumes serial bytes arrive from a character receiver on clk_i and
 * replies are taken by a transmitter with valid/ready. Pin 5 and beam
 * states come from outside and are synchronised here.
 */
`timescale 1ns/10ps

module bscas_top
   import bscas_pkg::*;
#(
   parameter int NB = 16,
   parameter int CLKS_PER_MS_P = CLKS_PER_MS,
   parameter int MB_GAP_CLKS_P = MB_GAP_CLKS
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [NB-1:0] beams_i,
   input wire logic cascade_en_i,
   input wire logic role_i,
   input wire logic [15:0] cycle_ms_i,
   input wire logic [15:0] delay_us_i,
   input wire logic pin5_dir_i,
   input wire logic pin5_sw_i,
   input wire logic [3:0] pin5_outfn_i,
   input wire logic [3:0] pin5_infn_i,
   input wire logic pin5_i,
   output logic pin5_o,
   output logic pin5_oe_n_o,
   output logic scan_start_o,
   input wire logic mb_rx_valid_i,
   input wire logic [7:0] mb_rx_data_i,
   output logic mb_tx_valid_o,
   output logic [7:0] mb_tx_data_o,
   input wire logic mb_tx_ready_i,
   input wire logic iol_wr_i,
   input wire logic [IOL_W-1:0] iol_data_i,
   output logic [31:0] smooth_cfg_o,
   output logic [NB-1:0] intr_eval_o,
   output logic [NB-1:0] free_eval_o,
   output logic intr_det_o,
   output logic free_det_o
);

   localparam logic [31:0] GAP = 32'(MB_GAP_CLKS_P);
   localparam logic [7:0] TRIG_LEN = 8'(TRIG_CLKS);

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   logic [NB-1:0] beams_s1_q, beams_s2_q;
   logic pin5_s1_q, pin5_s2_q;

   // Two flops on the beam and pin 5 inputs
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         beams_s1_q <= '0;
         beams_s2_q <= '0;
         pin5_s1_q <= 1'b0;
         pin5_s2_q <= 1'b0;
      end else begin
         beams_s1_q <= beams_i;
         beams_s2_q <= beams_s1_q;
         pin5_s1_q <= pin5_i;
         pin5_s2_q <= pin5_s1_q;
      end
   end

   // ------------------------------------------------------------------
   // Serial request receiver
   // ------------------------------------------------------------------
   logic [31:0] gap_q;
   logic [3:0] rx_idx_q, cur_idx;
   logic rx_bad_q, cur_bad, rx_bad_d;
   logic [15:0] rx_crc_q, cur_crc, rx_crc_d;
   logic [31:0] rx_data_q;
   logic frame_idle, wr_ok;

   // Silence counter marks frame boundaries
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         gap_q <= GAP;
      end else if (mb_rx_valid_i) begin
         gap_q <= '0;
      end else if (gap_q != GAP) begin
         gap_q <= gap_q + 32'h1;
      end
   end

   // First byte after silence starts a fresh frame
   assign frame_idle = (gap_q == GAP);
   assign cur_idx = frame_idle ? 4'h0 : rx_idx_q;
   assign cur_bad = frame_idle ? 1'b0 : rx_bad_q;
   assign cur_crc = frame_idle ? CRC_INIT : rx_crc_q;
   assign rx_crc_d = crc_byte(cur_crc, mb_rx_data_i);
   assign rx_bad_d = cur_bad | (cur_idx == 4'hf) |
      ((cur_idx < MB_HDR_LEN) && (mb_rx_data_i != mb_hdr_byte(cur_idx)));
   // Accepted only when header and check agree and no reply is pending
   assign wr_ok = mb_rx_valid_i && (cur_idx == MB_REQ_LAST) && !rx_bad_d &&
      (rx_crc_d == 16'h0000) && !mb_tx_valid_o;

   // Byte position, error flag, running check and data capture
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rx_idx_q <= '0;
         rx_bad_q <= 1'b0;
         rx_crc_q <= CRC_INIT;
         rx_data_q <= '0;
      end else if (mb_rx_valid_i) begin
         rx_idx_q <= (cur_idx == 4'hf) ? cur_idx : cur_idx + 4'h1;
         rx_bad_q <= rx_bad_d;
         rx_crc_q <= rx_crc_d;
         if (cur_idx >= MB_HDR_LEN && cur_idx < MB_HDR_LEN + 4'h4) begin
            rx_data_q <= {rx_data_q[23:0], mb_rx_data_i};
         end
      end
   end

   // ------------------------------------------------------------------
   // Smoothing configuration word
   // ------------------------------------------------------------------
   logic [31:0] cfg_q;

   // Serial write wins over an object write in the same cycle
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cfg_q <= SMOOTH_CFG_RST;
      end else if (wr_ok) begin
         cfg_q <= rx_data_q;
      end else if (iol_wr_i) begin
         cfg_q[IOL_W-1:0] <= iol_data_i;
      end
   end

   assign smooth_cfg_o = cfg_q;

   // ------------------------------------------------------------------
   // Reply transmitter
   // ------------------------------------------------------------------
   logic [3:0] tx_idx_q;
   logic [15:0] tx_crc_q, tx_crc_d;

   assign tx_crc_d = crc_byte(tx_crc_q, mb_tx_data_o);

   // Six header bytes then check low and high
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         tx_idx_q <= '0;
         tx_crc_q <= CRC_INIT;
         mb_tx_valid_o <= 1'b0;
         mb_tx_data_o <= '0;
      end else if (wr_ok) begin
         tx_idx_q <= '0;
         tx_crc_q <= CRC_INIT;
         mb_tx_valid_o <= 1'b1;
         mb_tx_data_o <= mb_hdr_byte(4'h0);
      end else if (mb_tx_valid_o && mb_tx_ready_i) begin
         tx_idx_q <= tx_idx_q + 4'h1;
         if (tx_idx_q == MB_RSP_LAST) begin
            mb_tx_valid_o <= 1'b0;
         end
         if (tx_idx_q < MB_RSP_HDR) begin
            tx_crc_q <= tx_crc_d;
         end
         if (tx_idx_q + 4'h1 < MB_RSP_HDR) begin
            mb_tx_data_o <= mb_hdr_byte(tx_idx_q + 4'h1);
         end else if (tx_idx_q + 4'h1 == MB_RSP_HDR) begin
            mb_tx_data_o <= tx_crc_d[7:0];
         end else begin
            mb_tx_data_o <= tx_crc_q[15:8];
         end
      end
   end

   // ------------------------------------------------------------------
   // Beam evaluation
   // ------------------------------------------------------------------
   bscas_smooth #(.NB(NB)) u_smooth (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .beams_i(beams_s2_q),
      .thr_intr_i(cfg_q[SMOOTH_LSB +: THR_W]),
      .thr_free_i(cfg_q[INV_LSB +: THR_W]),
      .intr_eval_o(intr_eval_o),
      .free_eval_o(free_eval_o),
      .intr_det_o(intr_det_o),
      .free_det_o(free_det_o)
   );

   // ------------------------------------------------------------------
   // Cascade role and trigger
   // ------------------------------------------------------------------
   bscas_state_t state_q, state_d;
   logic drive_ok, accept_ok, dark, fire, lvl_now, lvl_q, trig_edge;
   logic ms_done, us_done;
   logic [15:0] cycle_units;
   logic [7:0] trig_cnt_q;

   // Role follows enable and function type
   always_comb begin
      case ({cascade_en_i, role_i})
         {1'b1, ROLE_MASTER}: state_d = CS_MASTER;
         {1'b1, ~ROLE_MASTER}: state_d = CS_SLAVE;
         default: state_d = CS_OFF;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_q <= CS_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // Pin 5 role gating and trigger conditions
   assign drive_ok = (state_d == CS_MASTER) && (pin5_dir_i == PIN_DIR_OUT) &&
      (pin5_outfn_i == PIN_FN_TRIG_OUT);
   assign accept_ok = (state_q == CS_SLAVE) && (pin5_dir_i == PIN_DIR_IN) &&
      (pin5_infn_i == PIN_FN_TRIG_IN);
   assign dark = (pin5_sw_i != PIN_SW_LIGHT);
   assign fire = (state_d == CS_MASTER) && ((state_q != CS_MASTER) || ms_done);
   assign lvl_now = pin5_s2_q ^ dark;
   assign trig_edge = accept_ok && lvl_now && !lvl_q;
   assign cycle_units = (cycle_ms_i == 16'h0000) ? 16'h0001 : cycle_ms_i;

   // Master cycle period in milliseconds
   bscas_timer #(.TICK(CLKS_PER_MS_P), .W(16)) u_ms_tmr (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .start_i(fire),
      .units_i(cycle_units),
      .done_o(ms_done)
   );

   // Slave delay in microseconds, restarted by each edge
   bscas_timer #(.TICK(CLKS_PER_US), .W(16)) u_us_tmr (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .start_i(trig_edge),
      .units_i(delay_us_i),
      .done_o(us_done)
   );

   // Trigger pulse, pin drive and scan start
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         lvl_q <= 1'b0;
         trig_cnt_q <= '0;
         pin5_o <= 1'b0;
         pin5_oe_n_o <= 1'b1;
         scan_start_o <= 1'b0;
      end else begin
         lvl_q <= lvl_now;
         trig_cnt_q <= fire ? TRIG_LEN : (trig_cnt_q != 8'h00 ? trig_cnt_q - 8'h01 : trig_cnt_q);
         pin5_o <= drive_ok ? ((fire || trig_cnt_q > 8'h01) ^ dark) : 1'b0;
         pin5_oe_n_o <= !drive_ok;
         scan_start_o <= fire || ((state_q == CS_SLAVE) && us_done);
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   int since_q, per_q;
   logic per_seen_q;

   // Cycles since last slave edge and since last scan
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         since_q <= 0;
         per_q <= 0;
         per_seen_q <= 1'b0;
      end else begin
         since_q <= trig_edge ? 0 : (since_q < 32'h7fff_fffe ? since_q + 1 : since_q);
         per_q <= scan_start_o ? 1 : (per_q < 32'h7fff_fffe ? per_q + 1 : per_q);
         per_seen_q <= (state_q == CS_MASTER) && (per_seen_q || scan_start_o);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence rsp_head_s;
      mb_tx_valid_o && mb_tx_data_o == MB_UNIT;
   endsequence

   sequence trig_high_s;
      !pin5_oe_n_o && (pin5_o != dark);
   endsequence

   reply_head_a: assert property (wr_ok |=> rsp_head_s)
      else $error("no reply after accepted write");
   cfg_bytes_a: assert property (
      wr_ok |=> smooth_cfg_o[15:8] == $past(rx_data_q[15:8]) && smooth_cfg_o[7:0] == $past(rx_data_q[7:0]))
      else $error("threshold bytes not stored");
   trig_scan_a: assert property (fire |=> scan_start_o)
      else $error("master scan not at trigger");
   trig_pulse_a: assert property (
      fire && drive_ok && $stable(pin5_sw_i) |=> trig_high_s [*2])
      else $error("trigger pulse not driven on pin");
   slave_pin_a: assert property (
      state_q == CS_SLAVE |=> pin5_oe_n_o)
      else $error("slave drives pin 5");
   master_period_a: assert property (
      scan_start_o && per_seen_q && $stable(cycle_ms_i) |-> per_q == int'(cycle_units) * CLKS_PER_MS_P)
      else $error("master cycle period wrong");
   slave_delay_a: assert property (
      scan_start_o && state_q == CS_SLAVE && $past(state_q) == CS_SLAVE && $stable(delay_us_i)
      |-> since_q == ((delay_us_i == 16'h0000) ? 1 : int'(delay_us_i) * CLKS_PER_US))
      else $error("slave delay wrong");

endmodule

// ### verification/bscas_host_model.sv
/*
 * Far-side model: serial parameter host with a stalling reply sink,
 * and a remote master curtain driving the cascade trigger line.
 * Assumes the block samples its inputs on rising edges of clk_i.
 */
`timescale 1ns/10ps
module bscas_host_model (
   input wire logic clk_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic tx_ready_o,
   output logic trig_o
);
   // ------------------------------------------------------------
   // Idle levels
   // ------------------------------------------------------------
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
      tx_ready_o = 1'b0;
      trig_o = 1'b0;
   end

   // Write frame sent back to back, unit 1 and function 0x10 first
   task automatic send_frame(input logic [103:0] f);
      for (int i = 12; i >= 0; i--) begin
         @(negedge clk_i);
         rx_valid_o <= 1'b1;
         rx_data_o <= f[i*8 +: 8];
      end
      @(negedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o <= ~rx_data_o; // Released data no longer valid
   endtask

   // Reply sink that stalls every other cycle
   task automatic get_reply(output logic [63:0] r, output int n);
      n = 0;
      r = '0;
      for (int k = 0; k < 40 && n < 8; k++) begin
         @(negedge clk_i);
         tx_ready_o = k[0];
         if (tx_ready_o && tx_valid_i) begin
            r = {r[55:0], tx_data_i};
            n++;
         end
      end
      @(negedge clk_i);
      tx_ready_o = 1'b0;
   endtask

   // Light-switching trigger pulse, high ten cycles
   task automatic trig_pulse();
      @(negedge clk_i);
      trig_o <= 1'b1;
      repeat (10) @(negedge clk_i);
      trig_o <= 1'b0;
   endtask
endmodule

// ### verification/tb.sv
/*
 * Self-checking bench: serial and object writes, smoothing, master
 * trigger timing and slave delayed scan with restart.
 * Assumes the far side is the host model; ms scaled to 20 clocks.
 */
`timescale 1ns/10ps
module tb;
   logic clk_i, resetn_i, cascade_en_i, role_i, pin5_dir_i, pin5_sw_i;
   logic [15:0] beams_i, cycle_ms_i, delay_us_i, iol_data_i, intr_eval_o, free_eval_o;
   logic [3:0] pin5_outfn_i, pin5_infn_i;
   logic iol_wr_i, pin5_o, pin5_oe_n_o, scan_start_o, intr_det_o, free_det_o;
   logic mb_rx_valid_i, mb_tx_valid_o, mb_tx_ready_i, trig;
   logic [7:0] mb_rx_data_i, mb_tx_data_o;
   logic [31:0] smooth_cfg_o;
   logic [63:0] rep;
   int n, error_cnt, tests_run;
   wire pin5_i_w;
   // Trigger line: block drives it when enabled, else the model
   assign pin5_i_w = pin5_oe_n_o ? trig : pin5_o;

   bscas_top #(.NB(16), .CLKS_PER_MS_P(20), .MB_GAP_CLKS_P(30)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .beams_i(beams_i), .cascade_en_i(cascade_en_i), .role_i(role_i), .cycle_ms_i(cycle_ms_i),
      .delay_us_i(delay_us_i), .pin5_dir_i(pin5_dir_i), .pin5_sw_i(pin5_sw_i), .pin5_outfn_i(pin5_outfn_i),
      .pin5_infn_i(pin5_infn_i), .pin5_i(pin5_i_w), .pin5_o(pin5_o), .pin5_oe_n_o(pin5_oe_n_o),
      .scan_start_o(scan_start_o), .mb_rx_valid_i(mb_rx_valid_i), .mb_rx_data_i(mb_rx_data_i),
      .mb_tx_valid_o(mb_tx_valid_o), .mb_tx_data_o(mb_tx_data_o), .mb_tx_ready_i(mb_tx_ready_i),
      .iol_wr_i(iol_wr_i), .iol_data_i(iol_data_i), .smooth_cfg_o(smooth_cfg_o), .intr_eval_o(intr_eval_o),
      .free_eval_o(free_eval_o), .intr_det_o(intr_det_o), .free_det_o(free_det_o));

   bscas_host_model host (.clk_i(clk_i), .tx_valid_i(mb_tx_valid_o), .tx_data_i(mb_tx_data_o),
      .rx_valid_o(mb_rx_valid_i), .rx_data_o(mb_rx_data_i), .tx_ready_o(mb_tx_ready_i), .trig_o(trig));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   // Beam vector, then sync and register latency
   task automatic set_beams(input logic [15:0] v);
      @(negedge clk_i);
      beams_i = v;
      repeat (4) @(negedge clk_i);
   endtask

   // Cycles until the next scan pulse, 200 at most
   task automatic wait_scan(output int c);
      c = 0;
      do begin
         @(negedge clk_i);
         c++;
      end while (!scan_start_o && c < 200);
   endtask

   task automatic final_report();
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Clock and watchdog
   // ------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   initial begin
      #600000;
      error_cnt++;
      final_report();
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      error_cnt = 0;
      tests_run = 0;
      resetn_i = 1'b0;
      beams_i = 16'h0000;
      cascade_en_i = 1'b0;
      role_i = 1'b1;
      cycle_ms_i = 16'h0002;
      delay_us_i = 16'h0003;
      pin5_dir_i = 1'b0;
      pin5_sw_i = 1'b0;
      pin5_outfn_i = 4'h3;
      pin5_infn_i = 4'h0;
      iol_wr_i = 1'b0;
      iol_data_i = 16'h0000;
      repeat (8) @(negedge clk_i);
      resetn_i = 1'b1;
      check("cfg_reset", smooth_cfg_o, 64'h101);
      check("oe_n_reset", pin5_oe_n_o, 64'h1);
      // Good write, reply, then a frame with a broken check
      host.send_frame(104'h01_10_00_47_00_02_04_00_00_04_01_75_79);
      host.get_reply(rep, n);
      check("cfg_serial", smooth_cfg_o, 64'h0401);
      check("reply", rep, 64'h0110_0047_0002_f1dd);
      check("reply_len", n, 64'h8);
      repeat (40) @(negedge clk_i);
      host.send_frame(104'h01_10_00_47_00_02_04_00_00_01_04_b6_2b);
      host.get_reply(rep, n);
      check("cfg_bad_crc", smooth_cfg_o, 64'h0401);
      check("no_reply", n, 64'h0);
      $display("test serial done");
      // Smoothing 4, inverted 1
      set_beams(16'h0007);
      check("intr_det_3", intr_det_o, 64'h0);
      check("intr_eval_3", intr_eval_o, 64'h0);
      set_beams(16'h000f);
      check("intr_det_4", intr_det_o, 64'h1);
      check("intr_eval_4", intr_eval_o, 64'h000f);
      check("free_eval_1", free_eval_o, 64'hfff0);
      // Object write: smoothing 1, inverted 4
      @(negedge clk_i);
      iol_data_i = 16'h0104;
      iol_wr_i = 1'b1;
      @(negedge clk_i);
      iol_wr_i = 1'b0;
      check("cfg_object", smooth_cfg_o, 64'h0104);
      set_beams(16'h1fff);
      check("free_det_3", free_det_o, 64'h0);
      check("free_eval_3", free_eval_o, 64'h0);
      set_beams(16'h0fff);
      check("free_det_4", free_det_o, 64'h1);
      check("free_eval_4", free_eval_o, 64'hf000);
      check("intr_eval_1", intr_eval_o, 64'h0fff);
      $display("test smoothing done");
      // Cascading off: no scans
      wait_scan(n);
      check("off_no_scan", n, 64'd200);
      // Master, period 2 ms of 20 clocks
      @(negedge clk_i);
      cascade_en_i = 1'b1;
      wait_scan(n);
      check("m_trig_at_scan", pin5_o, 64'h1);
      check("m_drive", pin5_oe_n_o, 64'h0);
      repeat (9) @(negedge clk_i);
      check("m_pulse_high", pin5_o, 64'h1);
      @(negedge clk_i);
      check("m_pulse_low", pin5_o, 64'h0);
      // Dark switching inverts the idle level of the pin
      pin5_sw_i = 1'b1;
      @(negedge clk_i);
      check("m_dark_idle", pin5_o, 64'h1);
      pin5_sw_i = 1'b0;
      wait_scan(n);
      check("m_period", n, 64'd29);
      $display("test master done");
      // Slave, delay 3 us after trigger
      @(negedge clk_i);
      role_i = 1'b0;
      pin5_dir_i = 1'b1;
      pin5_infn_i = 4'h1;
      repeat (30) @(negedge clk_i);
      check("s_no_drive", pin5_oe_n_o, 64'h1);
      host.trig_pulse();
      wait_scan(n);
      check("s_delay", n, 64'd23);
      // Second slave delay of 5 us restarts at the later edge, retriggered mid-delay
      delay_us_i = 16'h0005;
      repeat (10) @(negedge clk_i);
      host.trig_pulse();
      repeat (4) @(negedge clk_i);
      host.trig_pulse();
      wait_scan(n);
      check("s_restart", n, 64'd43);
      $display("test slave done");
      final_report();
   end
endmodule
